//--- common/pccs_pkg.sv
// Shared constants and types of the protocol controller configuration bank.
package pccs_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] ADDR_SETUP_DELAY = 8'h00;
  localparam logic [7:0] ADDR_PARITY_CTRL = 8'h04;
  localparam logic [7:0] ADDR_INT_MASK    = 8'h08;
  localparam logic [7:0] ADDR_CMD_LENGTH  = 8'h0c;
  localparam logic [7:0] ADDR_DMA_MODE    = 8'h10;
  localparam logic [7:0] ADDR_INT_STATUS  = 8'h14;

  // Writable bits of each register; the rest read as zero.
  localparam logic [7:0] MASK_SETUP_DELAY = 8'h0f;
  localparam logic [7:0] MASK_PARITY_CTRL = 8'hfb;
  localparam logic [7:0] MASK_INT_MASK    = 8'hbf;
  localparam logic [7:0] MASK_CMD_LENGTH  = 8'hff;
  localparam logic [7:0] MASK_DMA_MODE    = 8'h30;

  // Values after reset.
  localparam logic [7:0] RST_SETUP_DELAY = 8'h00;
  localparam logic [7:0] RST_PARITY_CTRL = 8'h00;
  localparam logic [7:0] RST_INT_MASK    = 8'h00;
  localparam logic [7:0] RST_CMD_LENGTH  = 8'h00;
  localparam logic [7:0] RST_DMA_MODE    = 8'h00;

  // Field positions.
  localparam int INT_MASTER_BIT = 7;
  localparam int INT_GROUPS     = 6;
  localparam int DMA_WIDE_BIT   = 5;
  localparam int DMA_BURST_BIT  = 4;
  localparam int GRP6_LSB       = 0;
  localparam int GRP7_LSB       = 4;

  // Setup delay code zero stands for this many cycles.
  localparam logic [4:0] SETUP_ZERO_CYCLES = 5'h10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Bit layout matches the parity control register, bit 7 first.
  typedef struct packed {
    logic scsi_chk;
    logic scsi_gen;
    logic odd;
    logic host_chk;
    logic host_gen;
    logic unused;
    logic dma_chk;
    logic dma_gen;
  } pccs_par_cfg_s;

  // Parity enables handed to the data paths.
  typedef struct packed {
    logic scsi_chk;
    logic scsi_gen;
    logic host_chk;
    logic host_gen;
    logic dma_chk;
    logic dma_gen;
    logic odd;
  } pccs_par_en_s;

  typedef enum logic [2:0] {
    PH_DATA_OUT,
    PH_DATA_IN,
    PH_COMMAND,
    PH_STATUS,
    PH_MSG_OUT,
    PH_MSG_IN,
    PH_NONE
  } pccs_phase_e;

endpackage : pccs_pkg

//--- verilog/pccs_config.sv
// Configuration register bank with setup timer, parity gating and DMA handshake.
//
// Contract
// - Target: wait programmed cycles from data to request strobe; code 0 is 16.
// - Initiator: same programmed wait from data to acknowledge strobe.
// - No parity checking before apply-configuration loads the parity setup.
// - Bus check bit enables checks on phases chosen by initiator or target role.
// - Bus generate bit acts only in data phases, both directions.
// - System parity type bit: one is odd, zero is even, host and DMA.
// - Host check bit checks register writes and program-transfer data traffic.
// - Host generate bit for program data; register reads generate unless a register write is flagged too.
// - DMA check bit checks DMA data in both directions during DMA phases.
// - DMA generate bit generates parity on DMA data in DMA phases.
// - External bus accesses get no parity check nor generation.
// - Master enable bit gates interrupt output; clear masks every cause.
// - Enable bit k, k 0 to 5, masks codes whose top three bits equal k; groups 6 and 7 never interrupt.
// - Every interrupt code is recorded in status even when masked.
// - Low nibble n gives group 6 length 2n bytes; zero is unspecified.
// - High nibble gives group 7 length, same encoding.
// - DMA width bit set is 16-bit path, clear is 8-bit.
// - Burst mode holds request while transfer possible; else handshake.
// - To controller: present data, raise request, drop it on acknowledge.
// - From controller: raise request, capture data, drop on acknowledge.
// - Next request waits until previous acknowledge is negated.
`timescale 1ns/1ps
`default_nettype none

module pccs_config (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  // AXI4-Lite slave.
  input  wire logic [31:0]          i_awaddr,
  input  wire logic                 i_awvalid,
  output logic                      o_awready,
  input  wire logic [31:0]          i_wdata,
  input  wire logic [3:0]           i_wstrb,
  input  wire logic                 i_wvalid,
  output logic                      o_wready,
  output logic [1:0]                o_bresp,
  output logic                      o_bvalid,
  input  wire logic                 i_bready,
  input  wire logic [31:0]          i_araddr,
  input  wire logic                 i_arvalid,
  output logic                      o_arready,
  output logic [31:0]               o_rdata,
  output logic [1:0]                o_rresp,
  output logic                      o_rvalid,
  input  wire logic                 i_rready,
  // Asynchronous transfer setup timer.
  input  wire logic                 i_async_start,
  input  wire logic                 i_async_release,
  input  wire logic                 i_is_initiator,
  output logic                      o_async_req,
  output logic                      o_async_ack,
  // Parity configuration and context.
  input  wire logic                 i_apply_config,
  input  wire pccs_pkg::pccs_phase_e i_phase,
  input  wire logic                 i_ext_bus_access,
  input  wire logic                 i_host_reg_write,
  input  wire logic                 i_host_reg_read,
  input  wire logic                 i_pio_data_access,
  input  wire logic                 i_dma_data_phase,
  output pccs_pkg::pccs_par_en_s    o_par_en,
  // Interrupt codes and output.
  input  wire logic [7:0]           i_int_code,
  input  wire logic                 i_int_valid,
  output logic                      o_int,
  // Vendor command lengths in bytes, zero when unspecified.
  output logic [4:0]                o_grp6_len,
  output logic [4:0]                o_grp7_len,
  // DMA handshake.
  input  wire logic                 i_dma_possible,
  input  wire logic                 i_dma_to_ctrl,
  input  wire logic [15:0]          i_dma_tx_data,
  input  wire logic [15:0]          i_dma_rx_pins,
  input  wire logic                 i_dma_ack_n,
  output logic                      o_dma_req,
  output logic [15:0]               o_dma_data,
  output logic                      o_dma_data_oe,
  output logic [15:0]               o_dma_rx_data,
  output logic                      o_dma_item_done,
  output logic                      o_dma_wide
);

  default clocking pccs_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  typedef enum logic [1:0] {
    DH_IDLE,
    DH_SETUP,
    DH_REQ,
    DH_WAIT_NEG
  } pccs_dh_e;

  function automatic logic pccs_mapped(input logic [31:0] a);
    pccs_mapped = (a[31:8] == 24'h000000) &&
                  (a[7:0] == pccs_pkg::ADDR_SETUP_DELAY ||
                   a[7:0] == pccs_pkg::ADDR_PARITY_CTRL ||
                   a[7:0] == pccs_pkg::ADDR_INT_MASK    ||
                   a[7:0] == pccs_pkg::ADDR_CMD_LENGTH  ||
                   a[7:0] == pccs_pkg::ADDR_DMA_MODE    ||
                   a[7:0] == pccs_pkg::ADDR_INT_STATUS);
  endfunction : pccs_mapped

  function automatic logic [4:0] pccs_cmd_len(input logic [3:0] f);
    pccs_cmd_len = {f, 1'b0};
  endfunction : pccs_cmd_len

  logic [7:0]  setup_r, parity_r, int_mask_r, cmd_len_r, dma_mode_r;
  logic        aw_full_r, w_full_r;
  logic [31:0] aw_addr_r;
  logic [7:0]  w_byte_r;
  logic        w_lane0_r;
  logic        wr_go;
  logic [7:0]  wr_off;

  // ---------------- AXI4-Lite slave ----------------
  // Address and data are parked separately so they may arrive in any order.
  assign o_awready = !aw_full_r && !o_bvalid;
  assign o_wready  = !w_full_r && !o_bvalid;
  assign o_arready = !o_rvalid;
  assign wr_go     = aw_full_r && w_full_r && !o_bvalid;
  assign wr_off    = aw_addr_r[7:0];

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= 32'h00000000;
    end else if (i_ce) begin
      if (i_awvalid && o_awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= i_awaddr;
      end else if (wr_go) begin
        aw_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      w_full_r  <= 1'b0;
      w_byte_r  <= 8'h00;
      w_lane0_r <= 1'b0;
    end else if (i_ce) begin
      if (i_wvalid && o_wready) begin
        w_full_r  <= 1'b1;
        w_byte_r  <= i_wdata[7:0];
        w_lane0_r <= i_wstrb[0];
      end else if (wr_go) begin
        w_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp  <= pccs_pkg::RESP_OKAY;
    end else if (i_ce) begin
      if (wr_go) begin
        o_bvalid <= 1'b1;
        o_bresp  <= pccs_mapped(aw_addr_r) ? pccs_pkg::RESP_OKAY
                                           : pccs_pkg::RESP_SLVERR;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Only byte lane 0 carries register bits, so only its strobe matters.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      setup_r    <= pccs_pkg::RST_SETUP_DELAY;
      parity_r   <= pccs_pkg::RST_PARITY_CTRL;
      int_mask_r <= pccs_pkg::RST_INT_MASK;
      cmd_len_r  <= pccs_pkg::RST_CMD_LENGTH;
      dma_mode_r <= pccs_pkg::RST_DMA_MODE;
    end else if (i_ce && wr_go && w_lane0_r &&
                 aw_addr_r[31:8] == 24'h000000) begin
      case (wr_off)
        pccs_pkg::ADDR_SETUP_DELAY:
          setup_r <= w_byte_r & pccs_pkg::MASK_SETUP_DELAY;
        pccs_pkg::ADDR_PARITY_CTRL:
          parity_r <= w_byte_r & pccs_pkg::MASK_PARITY_CTRL;
        pccs_pkg::ADDR_INT_MASK:
          int_mask_r <= w_byte_r & pccs_pkg::MASK_INT_MASK;
        pccs_pkg::ADDR_CMD_LENGTH:
          cmd_len_r <= w_byte_r & pccs_pkg::MASK_CMD_LENGTH;
        pccs_pkg::ADDR_DMA_MODE:
          dma_mode_r <= w_byte_r & pccs_pkg::MASK_DMA_MODE;
        default: ;
      endcase
    end
  end

  logic [7:0] int_code_r;
  logic       int_pend_r;
  logic [7:0] rd_byte;

  always_comb begin
    case (i_araddr[7:0])
      pccs_pkg::ADDR_SETUP_DELAY: rd_byte = setup_r;
      pccs_pkg::ADDR_PARITY_CTRL: rd_byte = parity_r;
      pccs_pkg::ADDR_INT_MASK:    rd_byte = int_mask_r;
      pccs_pkg::ADDR_CMD_LENGTH:  rd_byte = cmd_len_r;
      pccs_pkg::ADDR_DMA_MODE:    rd_byte = dma_mode_r;
      pccs_pkg::ADDR_INT_STATUS:  rd_byte = int_code_r;
      default:                    rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h00000000;
      o_rresp  <= pccs_pkg::RESP_OKAY;
    end else if (i_ce) begin
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rdata  <= pccs_mapped(i_araddr) ? {24'h000000, rd_byte}
                                          : 32'h00000000;
        o_rresp  <= pccs_mapped(i_araddr) ? pccs_pkg::RESP_OKAY
                                          : pccs_pkg::RESP_SLVERR;
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ---------------- Asynchronous setup timer ----------------
  logic [4:0] setup_cnt_r;
  logic       strobe_r;
  logic       role_init_r;
  logic [4:0] setup_cycles;

  assign setup_cycles = (setup_r[3:0] == 4'h0) ? pccs_pkg::SETUP_ZERO_CYCLES
                                               : {1'b0, setup_r[3:0]};

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      setup_cnt_r <= 5'h00;
      strobe_r    <= 1'b0;
      role_init_r <= 1'b0;
    end else if (i_ce) begin
      if (i_async_start) begin
        setup_cnt_r <= setup_cycles;
        strobe_r    <= 1'b0;
        role_init_r <= i_is_initiator;
      end else if (setup_cnt_r != 5'h00) begin
        setup_cnt_r <= setup_cnt_r - 5'h01;
        strobe_r    <= (setup_cnt_r == 5'h01);
      end else if (i_async_release) begin
        strobe_r <= 1'b0;
      end
    end
  end

  assign o_async_req = strobe_r && !role_init_r;
  assign o_async_ack = strobe_r && role_init_r;

  // ---------------- Parity configuration ----------------
  // The register may be rewritten freely; only the apply command makes it live.
  pccs_pkg::pccs_par_cfg_s act_r;
  logic                    par_loaded_r;
  logic                    data_ph, scsi_chk_ph, pio;
  pccs_pkg::pccs_par_en_s  par_nxt;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      act_r        <= pccs_pkg::pccs_par_cfg_s'(pccs_pkg::RST_PARITY_CTRL);
      par_loaded_r <= 1'b0;
    end else if (i_ce && i_apply_config) begin
      act_r        <= pccs_pkg::pccs_par_cfg_s'(parity_r);
      par_loaded_r <= 1'b1;
    end
  end

  assign data_ph = (i_phase == pccs_pkg::PH_DATA_IN) ||
                   (i_phase == pccs_pkg::PH_DATA_OUT);
  assign pio     = i_pio_data_access && data_ph;

  always_comb begin
    if (i_is_initiator) begin
      scsi_chk_ph = data_ph || (i_phase == pccs_pkg::PH_MSG_IN) ||
                    (i_phase == pccs_pkg::PH_STATUS);
    end else begin
      scsi_chk_ph = data_ph || (i_phase == pccs_pkg::PH_MSG_OUT) ||
                    (i_phase == pccs_pkg::PH_COMMAND);
    end
    par_nxt.scsi_chk = par_loaded_r && act_r.scsi_chk && scsi_chk_ph;
    par_nxt.scsi_gen = act_r.scsi_gen && data_ph;
    par_nxt.host_chk = par_loaded_r && act_r.host_chk &&
                       (i_host_reg_write || pio);
    par_nxt.host_gen = (act_r.host_gen && pio) ||
                       (i_host_reg_read && !i_host_reg_write);
    par_nxt.dma_chk  = par_loaded_r && act_r.dma_chk &&
                       i_dma_data_phase;
    par_nxt.dma_gen  = act_r.dma_gen && i_dma_data_phase;
    par_nxt.odd      = act_r.odd;
    if (i_ext_bus_access) begin
      par_nxt = '{default: 1'b0, odd: act_r.odd};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_par_en <= '0;
    end else if (i_ce) begin
      o_par_en <= par_nxt;
    end
  end

  // ---------------- Interrupt status and masking ----------------
  logic st_read;
  logic [2:0] grp;

  assign st_read = i_arvalid && o_arready &&
                   i_araddr[7:0] == pccs_pkg::ADDR_INT_STATUS;

  // A new code in the cycle of a status read stays pending: set beats clear.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      int_code_r <= 8'h00;
      int_pend_r <= 1'b0;
    end else if (i_ce) begin
      if (i_int_valid) begin
        int_code_r <= i_int_code;
        int_pend_r <= 1'b1;
      end else if (st_read) begin
        int_pend_r <= 1'b0;
      end
    end
  end

  assign grp   = int_code_r[7:5];
  assign o_int = int_pend_r && int_mask_r[pccs_pkg::INT_MASTER_BIT] &&
                 grp < 3'(pccs_pkg::INT_GROUPS) && int_mask_r[grp];

  // ---------------- Command lengths and DMA mode ----------------
  assign o_grp6_len = pccs_cmd_len(cmd_len_r[pccs_pkg::GRP6_LSB +: 4]);
  assign o_grp7_len = pccs_cmd_len(cmd_len_r[pccs_pkg::GRP7_LSB +: 4]);
  assign o_dma_wide = dma_mode_r[pccs_pkg::DMA_WIDE_BIT];

  // ---------------- DMA handshake ----------------
  logic        ack_s1_r, ack_s2_r;
  logic [15:0] rx_s1_r, rx_s2_r;
  logic        dack;
  logic        burst;
  logic        hs_req_r;
  pccs_dh_e    dh_r;

  // Pins from the controller are raw asynchronous inputs.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ack_s1_r <= 1'b1;
      ack_s2_r <= 1'b1;
      rx_s1_r  <= 16'h0000;
      rx_s2_r  <= 16'h0000;
    end else if (i_ce) begin
      ack_s1_r <= i_dma_ack_n;
      ack_s2_r <= ack_s1_r;
      rx_s1_r  <= i_dma_rx_pins;
      rx_s2_r  <= rx_s1_r;
    end
  end

  assign dack  = !ack_s2_r;
  assign burst = dma_mode_r[pccs_pkg::DMA_BURST_BIT];

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      dh_r            <= DH_IDLE;
      hs_req_r        <= 1'b0;
      o_dma_data      <= 16'h0000;
      o_dma_data_oe   <= 1'b0;
      o_dma_rx_data   <= 16'h0000;
      o_dma_item_done <= 1'b0;
    end else if (i_ce) begin
      o_dma_item_done <= 1'b0;
      case (dh_r)
        DH_IDLE: begin
          if (i_dma_possible && !burst && !dack) begin
            if (i_dma_to_ctrl) begin
              o_dma_data    <= i_dma_tx_data;
              o_dma_data_oe <= 1'b1;
              dh_r          <= DH_SETUP;
            end else begin
              o_dma_data_oe <= 1'b0;
              hs_req_r      <= 1'b1;
              dh_r          <= DH_REQ;
            end
          end
        end
        DH_SETUP: begin
          hs_req_r <= 1'b1;
          dh_r     <= DH_REQ;
        end
        DH_REQ: begin
          if (dack) begin
            hs_req_r        <= 1'b0;
            o_dma_item_done <= 1'b1;
            if (!o_dma_data_oe) begin
              o_dma_rx_data <= rx_s2_r;
            end
            dh_r <= DH_WAIT_NEG;
          end
        end
        DH_WAIT_NEG: begin
          o_dma_data_oe <= 1'b0;
          if (!dack) begin
            dh_r <= DH_IDLE;
          end
        end
        default: begin
          dh_r     <= DH_IDLE;
          hs_req_r <= 1'b0;
        end
      endcase
    end
  end

  // Burst mode bypasses the per-item handshake entirely.
  assign o_dma_req = burst ? i_dma_possible : hs_req_r;

  // ---------------- Assertions ----------------
  logic [4:0] since_start_r;
  logic [4:0] expect_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      since_start_r <= 5'h00;
      expect_r      <= 5'h00;
    end else if (i_ce) begin
      if (i_async_start) begin
        since_start_r <= 5'h00;
        expect_r      <= setup_cycles;
      end else if (since_start_r != 5'h1f) begin
        since_start_r <= since_start_r + 5'h01;
      end
    end
  end

  target_setup_a: assert property (
    $rose(o_async_req) |-> since_start_r == expect_r)
    else $error("request strobe not after programmed setup");

  init_setup_a: assert property (
    $rose(o_async_ack) |-> since_start_r == expect_r)
    else $error("acknowledge strobe not after programmed setup");

  parity_unloaded_a: assert property (
    (o_par_en.scsi_chk || o_par_en.host_chk || o_par_en.dma_chk) |->
      par_loaded_r)
    else $error("parity check before configuration applied");

  ext_access_a: assert property (
    $past(i_ext_bus_access) && $past(i_ce) |->
      !(o_par_en.scsi_chk || o_par_en.scsi_gen || o_par_en.host_chk ||
        o_par_en.host_gen || o_par_en.dma_chk || o_par_en.dma_gen))
    else $error("parity active during external access");

  host_read_a: assert property (
    i_ce && i_host_reg_read && !i_host_reg_write && !i_ext_bus_access |=>
      o_par_en.host_gen)
    else $error("register read without generated parity");

  int_master_a: assert property (
    !int_mask_r[pccs_pkg::INT_MASTER_BIT] |-> !o_int)
    else $error("interrupt raised with master enable clear");

  int_record_a: assert property (
    i_ce && i_int_valid |=> int_pend_r && int_code_r == $past(i_int_code))
    else $error("interrupt code not recorded");

  cmd_length_a: assert property (
    o_grp6_len == 5'(2 * cmd_len_r[3:0]) &&
      o_grp7_len == 5'(2 * cmd_len_r[7:4]))
    else $error("command length decode wrong");

  burst_hold_a: assert property (
    burst && i_dma_possible |-> o_dma_req)
    else $error("burst request dropped while transfer possible");

  sequence dh_acked_s;
    i_ce && dh_r == DH_REQ && dack;
  endsequence

  dreq_drop_a: assert property (
    dh_acked_s |=> !hs_req_r && o_dma_item_done)
    else $error("request not dropped on acknowledge");

  no_redreq_a: assert property (
    $rose(hs_req_r) |-> !$past(dack))
    else $error("request raised before acknowledge negated");

endmodule : pccs_config

`default_nettype wire

//--- verification/pccs_dma_model.sv
// Behavioural DMA controller that answers the request handshake.
`timescale 1ns/1ps
`default_nettype none
module pccs_dma_model (
  input  wire logic        i_clk,
  input  wire logic        i_req,
  input  wire logic        i_slow,
  input  wire logic [15:0] i_send,
  output logic             o_ack_n,
  output logic [15:0]      o_pins
);
  initial begin
    o_ack_n = 1'b1;
    o_pins = 16'hffff;
    forever begin
      @(posedge i_clk);
      if (i_req) begin
        repeat (i_slow ? 6 : 1) @(posedge i_clk);
        o_pins <= i_send;
        @(posedge i_clk);
        o_ack_n <= 1'b0;
        while (i_req) @(posedge i_clk);
        o_ack_n <= 1'b1;
        // Released pins must not keep the last word on show.
        o_pins <= ~i_send;
      end
    end
  end
endmodule : pccs_dma_model
`default_nettype wire

//--- verification/pccs_config_tb.sv
// Self-checking bench for the configuration bank.
`timescale 1ns/1ps
`default_nettype none
module pccs_config_tb;
  logic i_ref_clk, i_rst, i_ce, i_awvalid, i_wvalid, i_bready, i_arvalid;
  logic i_rready, i_async_start, i_async_release, i_is_initiator;
  logic i_apply_config, i_ext_bus_access, i_host_reg_write, i_int_valid;
  logic i_host_reg_read, i_pio_data_access, i_dma_data_phase, hs, req_q;
  logic i_dma_possible, i_dma_to_ctrl, i_dma_ack_n, o_awready, o_wready;
  logic o_bvalid, o_arready, o_rvalid, o_async_req, o_async_ack, o_int;
  logic o_dma_req, o_dma_data_oe, o_dma_item_done, o_dma_wide, m_slow;
  logic [31:0] i_awaddr, i_wdata, i_araddr, o_rdata;
  logic [15:0] i_dma_tx_data, i_dma_rx_pins, o_dma_data, o_dma_rx_data;
  logic [15:0] m_send;
  logic [7:0]  i_int_code;
  logic [4:0]  o_grp6_len, o_grp7_len;
  logic [3:0]  i_wstrb;
  logic [1:0]  o_bresp, o_rresp;
  pccs_pkg::pccs_phase_e  i_phase;
  pccs_pkg::pccs_par_en_s o_par_en;
  localparam logic [1:0] OK = pccs_pkg::RESP_OKAY;
  int num_errors = 0;
  int num_checks = 0;

  pccs_config pccs_config_i (.*);
  pccs_dma_model pccs_dma_model_i (.i_clk(i_ref_clk), .i_req(o_dma_req),
    .i_slow(m_slow), .i_send(m_send), .o_ack_n(i_dma_ack_n),
    .o_pins(i_dma_rx_pins));

  always #50 i_ref_clk = ~i_ref_clk;

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // A new request while the acknowledge is still low breaks the handshake.
  always @(negedge i_ref_clk) begin
    if (hs && o_dma_req && !req_q) chk(i_dma_ack_n, 1'b1);
    req_q <= o_dma_req;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : step

  task automatic wr(input logic [7:0] a, d, input logic [1:0] r);
    logic [2:0] h;
    logic [1:0] b;
    i_awaddr <= {24'h0, a};
    i_wdata <= {24'h0, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(negedge i_ref_clk);
      h = {i_awvalid & o_awready, i_wvalid & o_wready, o_bvalid};
      b = o_bresp;
      @(posedge i_ref_clk);
      if (h[2]) i_awvalid <= 1'b0;
      if (h[1]) i_wvalid <= 1'b0;
    end while (!h[0]);
    chk(b, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, e, input logic [1:0] r);
    logic [1:0]  h;
    logic [33:0] v;
    i_araddr <= {24'h0, a};
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(negedge i_ref_clk);
      h = {i_arvalid & o_arready, o_rvalid};
      v = {o_rresp, o_rdata};
      @(posedge i_ref_clk);
      if (h[1]) i_arvalid <= 1'b0;
    end while (!h[0]);
    chk(v, {r, 24'h0, e});
  endtask : rd

  task automatic t_regs();
    logic [7:0] ad [5];
    logic [7:0] mk [5];
    ad = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    mk = '{8'h0f, 8'hfb, 8'hbf, 8'hff, 8'h30};
    for (int i = 0; i < 5; i++) begin
      rd(ad[i], 8'h00, OK);
      wr(ad[i], 8'hff, OK);
      rd(ad[i], mk[i], OK);
      wr(ad[i], 8'h00, OK);
    end
    wr(8'h18, 8'h5a, pccs_pkg::RESP_SLVERR);
    rd(8'h18, 8'h00, pccs_pkg::RESP_SLVERR);
    wr(8'h0c, 8'h0e, OK);
    chk({o_grp6_len, o_grp7_len}, {5'd28, 5'd0});
    wr(8'h0c, 8'hf1, OK);
    chk({o_grp6_len, o_grp7_len}, {5'd2, 5'd30});
    wr(8'h10, 8'h20, OK);
    chk(o_dma_wide, 1'b1);
  endtask : t_regs

  task automatic t_timer(input logic [3:0] c, input logic ini);
    int n;
    wr(8'h00, {4'h0, c}, OK);
    i_is_initiator <= ini;
    i_async_start <= 1'b1;
    step(1);
    i_async_start <= 1'b0;
    n = 0;
    do begin
      step(1);
      n++;
    end while (!(ini ? o_async_ack : o_async_req) && n < 40);
    chk(n, (c == 4'h0) ? 16 : c);
    i_async_release <= 1'b1;
    step(1);
    i_async_release <= 1'b0;
    chk({o_async_req, o_async_ack}, 2'b00);
  endtask : t_timer

  task automatic post(input logic [7:0] c, input logic e);
    i_int_code <= c;
    i_int_valid <= 1'b1;
    step(1);
    i_int_valid <= 1'b0;
    chk(o_int, e);
    rd(8'h14, c, OK);
  endtask : post

  task automatic t_int();
    for (int g = 0; g < 8; g++) begin
      wr(8'h08, 8'h80 | (8'h01 << g), OK);
      post({g[2:0], 5'h0a}, g < 6);
    end
    wr(8'h08, 8'h3f, OK);
    post(8'h2a, 1'b0);
    wr(8'h08, 8'hbe, OK);
    post(8'h0a, 1'b0);
  endtask : t_int

  task automatic t_par();
    wr(8'h04, 8'hfb, OK);
    i_phase <= pccs_pkg::PH_COMMAND;
    i_host_reg_write <= 1'b1;
    i_dma_data_phase <= 1'b1;
    step(2);
    chk({o_par_en.scsi_chk, o_par_en.host_chk, o_par_en.dma_chk}, 0);
    i_apply_config <= 1'b1;
    step(1);
    i_apply_config <= 1'b0;
    step(2);
    chk({o_par_en.scsi_chk, o_par_en.scsi_gen, o_par_en.host_chk,
      o_par_en.dma_chk, o_par_en.dma_gen, o_par_en.odd}, 6'h2f);
    i_is_initiator <= 1'b1;
    i_host_reg_write <= 1'b0;
    i_host_reg_read <= 1'b1;
    step(2);
    chk({o_par_en.scsi_chk, o_par_en.host_chk, o_par_en.host_gen}, 1);
    i_ext_bus_access <= 1'b1;
    step(2);
    chk({o_par_en.host_gen, o_par_en.dma_chk, o_par_en.dma_gen}, 0);
    i_ext_bus_access <= 1'b0;
    i_host_reg_read <= 1'b0;
    i_phase <= pccs_pkg::PH_DATA_IN;
    i_pio_data_access <= 1'b1;
    step(2);
    chk({o_par_en.scsi_chk, o_par_en.scsi_gen, o_par_en.host_chk,
      o_par_en.host_gen}, 4'hf);
    i_pio_data_access <= 1'b0;
    i_dma_data_phase <= 1'b0;
  endtask : t_par

  task automatic item(input logic to, input logic [15:0] d, input logic s);
    logic [15:0] q;
    int n;
    i_dma_to_ctrl <= to;
    i_dma_tx_data <= d;
    m_send <= d;
    m_slow <= s;
    i_dma_possible <= 1'b1;
    q = 16'h0;
    n = 0;
    do begin
      step(1);
      if (o_dma_req && o_dma_data_oe) q = o_dma_data;
      n++;
    end while (!o_dma_item_done && n < 60);
    chk({o_dma_item_done, to ? q : o_dma_rx_data}, {1'b1, d});
  endtask : item

  task automatic t_dma();
    hs = 1'b1;
    wr(8'h10, 8'h00, OK);
    item(1'b1, 16'ha5c3, 1'b0);
    item(1'b1, 16'h5a3c, 1'b1);
    item(1'b0, 16'h3c96, 1'b0);
    item(1'b0, 16'hc369, 1'b1);
    i_dma_possible <= 1'b0;
    step(12);
    hs = 1'b0;
    wr(8'h10, 8'h10, OK);
    i_dma_possible <= 1'b1;
    step(6);
    chk(o_dma_req, 1'b1);
    i_dma_possible <= 1'b0;
    step(1);
    chk(o_dma_req, 1'b0);
  endtask : t_dma

  initial begin
    i_ref_clk = 1'b0;
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_wstrb = 4'hf;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, hs, req_q} = '0;
    {i_async_start, i_async_release, i_is_initiator, i_apply_config} = '0;
    {i_ext_bus_access, i_host_reg_write, i_host_reg_read} = '0;
    {i_pio_data_access, i_dma_data_phase, i_int_valid, m_slow} = '0;
    {i_dma_possible, i_dma_to_ctrl, i_dma_tx_data, m_send} = '0;
    {i_awaddr, i_wdata, i_araddr, i_int_code} = '0;
    i_phase = pccs_pkg::PH_NONE;
    repeat (6) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(posedge i_ref_clk);
    t_regs();
    $display("test registers done");
    t_timer(4'h0, 1'b0);
    t_timer(4'h3, 1'b1);
    t_timer(4'hf, 1'b0);
    $display("test setup timer done");
    t_int();
    $display("test interrupts done");
    t_par();
    $display("test parity done");
    t_dma();
    $display("test dma done");
    give_verdict();
  end

  // The whole sequence needs a few hundred cycles.
  initial begin
    #(20000 * 100);
    num_errors++;
    give_verdict();
  end
endmodule : pccs_config_tb
`default_nettype wire
